// ==== rtl/tvfc_top.sv ====
`timescale 1ns/1ps
`include "tvfc_consts.svh"

module tvfc_top
  import tvfc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host command side
  input wire logic board_reset_i,
  input wire tvfc_load_t load_i,
  input wire logic start_i,
  input wire logic dut_ready_i,
  input wire logic [`TVFC_MODE_W-1:0] mode_sel_i,
  input wire logic crc_mode_i,
  input wire logic [`TVFC_ADDR_W-1:0] crc_chains_i,
  input wire logic count_rd_i,
  // host status side
  output logic [`TVFC_DATA_W-1:0] count_o,
  output logic result_ready_o,
  output logic error_flag_o,
  output logic busy_o,
  // vector bus toward the device under test
  output logic [`TVFC_MODE_W-1:0] mode_o,
  output tvfc_bus_t tx_o,
  input wire logic tx_ready_i,
  // result bus from the device under test
  input wire tvfc_bus_t result_i
);

  // ==========================================================
  // helpers
  // address step; wraps at the top of the store
  function automatic logic [`TVFC_ADDR_W-1:0] inc_addr(input logic [`TVFC_ADDR_W-1:0] a);
    inc_addr = a + `TVFC_ADDR_ONE;
  endfunction

  // a start is honoured only while the device under test reports ready
  function automatic logic start_ok(input logic go, input logic ready);
    start_ok = go & ready;
  endfunction

  // port a belongs to the host only while loading
  function automatic logic is_loading(input tvfc_state_t st);
    is_loading = (st == ST_LOAD);
  endfunction

  // values after power-up or a board reset; the vector store keeps its contents
  localparam tvfc_regs_t RST_VAL = '{
    st: ST_LOAD,
    wr_addr: `TVFC_ADDR_ZERO,
    last_addr: `TVFC_ADDR_ZERO,
    rd_addr: `TVFC_ADDR_ZERO,
    cmp_addr: `TVFC_ADDR_ZERO,
    crc_idx: `TVFC_ADDR_ZERO,
    rx_prev: 1'b0,
    rx_v: 1'b0,
    rx_d: `TVFC_CNT_ZERO,
    act_cnt: `TVFC_CNT_ZERO,
    lat_cnt: `TVFC_CNT_ZERO,
    err: 1'b0,
    mode: `TVFC_MODE_IDLE,
    res_rdy: 1'b0,
    loaded: 1'b0
  };

  tvfc_regs_t s_ff;
  tvfc_regs_t nxt_s;

  // ==========================================================
  // internal signals
  // vector store and fifo wiring
  logic ram_we_a;
  logic [`TVFC_ADDR_W-1:0] ram_addr_a;
  logic [`TVFC_ADDR_W-1:0] ram_addr_b;
  logic [`TVFC_DATA_W-1:0] ram_q_a;
  logic [`TVFC_DATA_W-1:0] ram_q_b;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_reset_n;
  // comparison and readout decode
  logic [`TVFC_ADDR_W-1:0] vec_last;
  logic [`TVFC_ADDR_W-1:0] cmp_base;
  logic rx_rise;
  logic cmp_en;
  logic take;
  logic mismatch;

  // ==========================================================
  // vector store; port a loads then reads out, port b compares
  tvfc_vram u_vram (
    .clk_i(clk_i),
    .we_a_i(ram_we_a),
    .addr_a_i(ram_addr_a),
    .wdata_a_i(load_i.data),
    .rdata_a_o(ram_q_a),
    .we_b_i(1'b0),
    .addr_b_i(ram_addr_b),
    .wdata_b_i(`TVFC_CNT_ZERO),
    .rdata_b_o(ram_q_b)
  );

  // ==========================================================
  // outgoing vector fifo; may later become a clock-crossing fifo
  // back-pressure from the device under test stalls the readout through the fifo
  assign fifo_reset_n = rst_n_i & ~board_reset_i;

  tvfc_fifo #(
    .WIDTH(`TVFC_DATA_W),
    .DEPTH(`TVFC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(fifo_reset_n),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(ram_q_a),
    .out_valid_o(tx_o.valid),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_o.data)
  );

  // ==========================================================
  // address split: crc mode keeps per-chain crcs after the vectors
  // a chain count not below the loaded byte count wraps the readout end,
  // so the host must load at least one vector byte besides the crcs
  always_comb
  begin
    vec_last = crc_mode_i ? (s_ff.last_addr - crc_chains_i) : s_ff.last_addr;
    cmp_base = crc_mode_i ? inc_addr(vec_last) : `TVFC_ADDR_ZERO;
  end

  // port a address: load pointer while loading, readout counter after start
  // port a is shared: host writes while loading, readout reads afterwards
  always_comb
  begin
    ram_we_a = is_loading(s_ff.st) & load_i.valid;
    ram_addr_a = is_loading(s_ff.st) ? s_ff.wr_addr : s_ff.rd_addr;
    fifo_in_valid = (s_ff.st == ST_SEND_PUSH);
  end

  // ==========================================================
  // comparison front end
  // port b answers one clock after its address, so the received byte is held
  // for a clock and met by the stored byte in the next one; a rising valid
  // points port b at the start of the expected data directly
  always_comb
  begin
    rx_rise = result_i.valid & ~s_ff.rx_prev;
    cmp_en = crc_mode_i ? (s_ff.st == ST_CRC) : 1'b1;
    take = result_i.valid & cmp_en;
    ram_addr_b = rx_rise ? cmp_base : s_ff.cmp_addr;
    mismatch = s_ff.rx_v & (ram_q_b != s_ff.rx_d);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rx_prev = result_i.valid;
    nxt_s.err = mismatch;

    // received byte waits one cycle for the stored byte
    nxt_s.rx_v = take;
    if (take)
    begin
      nxt_s.rx_d = result_i.data;
      nxt_s.cmp_addr = inc_addr(ram_addr_b);
    end

    // ping-pong counters; increments only, software keeps the total
    // a mismatch in the read clock seeds the cleared counter, so none is lost
    // an 8-bit add wraps from the top back to zero; no saturation
    if (count_rd_i)
    begin
      nxt_s.lat_cnt = s_ff.act_cnt;
      nxt_s.act_cnt = mismatch ? `TVFC_CNT_ONE : `TVFC_CNT_ZERO;
    end
    else if (mismatch)
    begin
      nxt_s.act_cnt = s_ff.act_cnt + `TVFC_CNT_ONE;
    end

    // sequencer: load, read/push pairs, drain, optional crc pull, done
    unique case (s_ff.st)
      ST_LOAD:
      begin
        if (load_i.valid)
        begin
          nxt_s.wr_addr = inc_addr(s_ff.wr_addr);
          nxt_s.loaded = 1'b1;
          if (load_i.last)
          begin
            nxt_s.last_addr = s_ff.wr_addr;
          end
        end
        // vectors must be loaded and the device under test ready before sending
        if (start_ok(start_i, dut_ready_i) & s_ff.loaded)
        begin
          nxt_s.st = ST_SEND_RD;
          nxt_s.rd_addr = `TVFC_ADDR_ZERO;
          nxt_s.mode = mode_sel_i;
          nxt_s.res_rdy = 1'b0;
        end
      end
      ST_SEND_RD:
      begin
        nxt_s.st = ST_SEND_PUSH; // stored byte appears next cycle
      end
      ST_SEND_PUSH:
      begin
        // at most one push every two clocks: the store needs a clock per new address
        if (fifo_in_ready)
        begin
          if (s_ff.rd_addr == vec_last)
          begin
            nxt_s.st = ST_DRAIN;
          end
          else
          begin
            nxt_s.rd_addr = inc_addr(s_ff.rd_addr);
            nxt_s.st = ST_SEND_RD;
          end
        end
      end
      ST_DRAIN:
      begin
        // the fifo may still hold bytes after the last push is taken;
        // completion waits until the device under test has taken them all
        if (!tx_o.valid)
        begin
          if (crc_mode_i)
          begin
            nxt_s.st = ST_CRC;
            nxt_s.mode = `TVFC_MODE_CRC_PULL;
            nxt_s.crc_idx = `TVFC_ADDR_ZERO;
          end
          else
          begin
            nxt_s.st = ST_DONE;
            nxt_s.res_rdy = 1'b1;
          end
        end
      end
      ST_CRC:
      begin
        if (take)
        begin
          nxt_s.crc_idx = inc_addr(s_ff.crc_idx);
        end
        // the pull ends once every chain has answered and the last byte
        // has left the compare stage
        if ((s_ff.crc_idx == crc_chains_i) & !s_ff.rx_v)
        begin
          nxt_s.st = ST_DONE;
          nxt_s.mode = `TVFC_MODE_IDLE;
          nxt_s.res_rdy = 1'b1;
        end
      end
      ST_DONE:
      begin
        // a finished run may be repeated without loading again
        if (start_ok(start_i, dut_ready_i))
        begin
          nxt_s.st = ST_SEND_RD;
          nxt_s.rd_addr = `TVFC_ADDR_ZERO;
          nxt_s.mode = mode_sel_i;
          nxt_s.res_rdy = 1'b0;
        end
      end
      default:
      begin
        nxt_s.st = ST_LOAD;
      end
    endcase
  end

  // ==========================================================
  // state register; board reset returns port a to loading
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || board_reset_i)
    begin
      s_ff <= RST_VAL;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs
  // count, ready and error flag come straight from flops so the host never sees a glitch
  assign count_o = s_ff.lat_cnt;
  assign result_ready_o = s_ff.res_rdy;
  assign error_flag_o = s_ff.err;
  // busy covers sending, draining and the crc pull
  assign busy_o = !is_loading(s_ff.st) & (s_ff.st != ST_DONE);
  assign mode_o = s_ff.mode;

endmodule

// ==== rtl/tvfc_consts.svh ====
`ifndef TVFC_CONSTS_SVH
`define TVFC_CONSTS_SVH

// ==========================================================
// sizes
`define TVFC_DATA_W 8
`define TVFC_ADDR_W 14
`define TVFC_DEPTH 16384
`define TVFC_FIFO_DEPTH 8
`define TVFC_MODE_W 3

// ==========================================================
// values
`define TVFC_ADDR_ZERO 14'h0000
`define TVFC_ADDR_ONE 14'h0001
`define TVFC_CNT_ZERO 8'h00
`define TVFC_CNT_ONE 8'h01
`define TVFC_MODE_IDLE 3'h0
`define TVFC_MODE_CRC_PULL 3'h7

`endif

// ==== rtl/tvfc_pkg.sv ====
`include "tvfc_consts.svh"

package tvfc_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_SEND_RD = 3'b001,
    ST_SEND_PUSH = 3'b010,
    ST_DRAIN = 3'b011,
    ST_CRC = 3'b100,
    ST_DONE = 3'b101
  } tvfc_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [`TVFC_DATA_W-1:0] data;
  } tvfc_bus_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [`TVFC_DATA_W-1:0] data;
  } tvfc_load_t;

  // ==========================================================
  // whole state of the checker
  typedef struct packed {
    tvfc_state_t st;
    logic [`TVFC_ADDR_W-1:0] wr_addr;
    logic [`TVFC_ADDR_W-1:0] last_addr;
    logic [`TVFC_ADDR_W-1:0] rd_addr;
    logic [`TVFC_ADDR_W-1:0] cmp_addr;
    logic [`TVFC_ADDR_W-1:0] crc_idx;
    logic rx_prev;
    logic rx_v;
    logic [`TVFC_DATA_W-1:0] rx_d;
    logic [`TVFC_DATA_W-1:0] act_cnt;
    logic [`TVFC_DATA_W-1:0] lat_cnt;
    logic err;
    logic [`TVFC_MODE_W-1:0] mode;
    logic res_rdy;
    logic loaded;
  } tvfc_regs_t;

endpackage

// ==== rtl/tvfc_vram.sv ====
`timescale 1ns/1ps
`include "tvfc_consts.svh"

module tvfc_vram
  import tvfc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // port a, read/write
  input wire logic we_a_i,
  input wire logic [`TVFC_ADDR_W-1:0] addr_a_i,
  input wire logic [`TVFC_DATA_W-1:0] wdata_a_i,
  output logic [`TVFC_DATA_W-1:0] rdata_a_o,
  // port b, read/write
  input wire logic we_b_i,
  input wire logic [`TVFC_ADDR_W-1:0] addr_b_i,
  input wire logic [`TVFC_DATA_W-1:0] wdata_b_i,
  output logic [`TVFC_DATA_W-1:0] rdata_b_o
);

  logic [`TVFC_DATA_W-1:0] mem [`TVFC_DEPTH];

  // ==========================================================
  // port a, registered read
  always_ff @(posedge clk_i)
  begin
    if (we_a_i)
    begin
      mem[addr_a_i] <= wdata_a_i;
    end
    rdata_a_o <= mem[addr_a_i];
  end

  // ==========================================================
  // port b, independent of port a
  always_ff @(posedge clk_i)
  begin
    if (we_b_i)
    begin
      mem[addr_b_i] <= wdata_b_i;
    end
    rdata_b_o <= mem[addr_b_i];
  end

endmodule

// ==== rtl/tvfc_fifo.sv ====
`timescale 1ns/1ps

module tvfc_fifo
  import tvfc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  // ==========================================================
  // handshakes, full and empty from the fill count
  assign in_ready_o = (cnt_ff != DEPTH[PW:0]);
  assign out_valid_o = (cnt_ff != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp_ff];

  // storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wp_ff] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop)
      begin
        rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ==== testbench/tvfc_properties.sv ====
`timescale 1ns/1ps
`include "tvfc_consts.svh"

module tvfc_properties
  import tvfc_pkg::*;
(
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic board_reset_i,
  // host side
  input wire logic start_i,
  input wire logic dut_ready_i,
  input wire logic [`TVFC_MODE_W-1:0] mode_sel_i,
  input wire logic count_rd_i,
  input wire logic [`TVFC_DATA_W-1:0] count_o,
  input wire logic result_ready_o,
  input wire logic error_flag_o,
  input wire logic busy_o,
  // vector and result buses
  input wire logic [`TVFC_MODE_W-1:0] mode_o,
  input wire tvfc_bus_t tx_o,
  input wire logic tx_ready_i,
  input wire tvfc_bus_t result_i
);
  // ========
  // helpers
  logic rst_any;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic rst_q_ff;
  logic rst_dis;
  assign rst_any = !rst_n_i || board_reset_i;
  // hold checks off for one clock after any reset so history settles
  always_ff @(posedge clk_i)
    rst_q_ff <= rst_any;
  assign rst_dis = rst_any || rst_q_ff;
  // flagged mismatches since the last count read
  assign nxt_acc = acc_ff + {7'h00, error_flag_o};
  always_ff @(posedge clk_i)
    acc_ff <= (rst_any || count_rd_i) ? 8'h00 : nxt_acc;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_dis);

  // ========
  // properties
  property p_rst;
    disable iff (1'b0) rst_any |=> count_o == 8'h00 && !busy_o && !error_flag_o && !tx_o.valid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_cnt;
    count_rd_i |=> count_o == $past(nxt_acc);
  endproperty
  a_cnt: assert property (p_cnt) else $error("latched count wrong");
  property p_hold;
    !count_rd_i |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without read");
  property p_idle;
    !result_i.valid [*4] |-> !error_flag_o;
  endproperty
  a_idle: assert property (p_idle) else $error("error without result");
  property p_mode;
    $rose(busy_o) |-> mode_o == $past(mode_sel_i);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken at start");
  property p_start;
    $rose(busy_o) |-> $past(start_i) && $past(dut_ready_i);
  endproperty
  a_start: assert property (p_start) else $error("send without ready start");
  property p_tx;
    tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data);
  endproperty
  a_tx: assert property (p_tx) else $error("tx byte dropped");
  property p_txb;
    tx_o.valid |-> busy_o;
  endproperty
  a_txb: assert property (p_txb) else $error("tx valid while idle");
  property p_rdy;
    result_ready_o |-> !busy_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready while busy");
endmodule

bind tvfc_top tvfc_properties u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .board_reset_i(board_reset_i), .start_i(start_i),
  .dut_ready_i(dut_ready_i), .mode_sel_i(mode_sel_i), .count_rd_i(count_rd_i),
  .count_o(count_o), .result_ready_o(result_ready_o), .error_flag_o(error_flag_o),
  .busy_o(busy_o), .mode_o(mode_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .result_i(result_i)
);

// ==== testbench/tvfc_partner.sv ====
`timescale 1ns/1ps
`include "tvfc_consts.svh"

module tvfc_partner
  import tvfc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // vector bus in
  input wire tvfc_bus_t tx_i,
  input wire logic [`TVFC_MODE_W-1:0] mode_i,
  output logic tx_ready_o,
  // result bus out
  output tvfc_bus_t result_o,
  // scenario controls
  input wire logic go_i,
  input wire logic flip_i,
  input wire logic stall_i,
  input wire logic [`TVFC_ADDR_W-1:0] chains_i
);
  logic [7:0] hist[$];
  logic [7:0] q[$];
  logic crc_seen = 1'b0;
  initial tx_ready_o = 1'b0;
  initial result_o = '0;
  // take bytes, replay them as one unbroken burst
  always @(posedge clk_i)
  begin
    tx_ready_o <= !stall_i;
    if (tx_i.valid && tx_ready_o)
      hist.push_back(tx_i.data);
    if (go_i)
    begin
      q = hist;
      hist.delete();
    end
    if (mode_i == `TVFC_MODE_CRC_PULL && !crc_seen)
    begin
      for (int i = hist.size() - int'(chains_i); i < hist.size(); i++)
        q.push_back(hist[i]);
      hist.delete();
    end
    crc_seen <= mode_i == `TVFC_MODE_CRC_PULL;
    // released bus inverts its previous data on every idle clock
    if (q.size() > 0)
      result_o <= '{1'b1, q.pop_front() ^ {8{flip_i}}};
    else
      result_o <= '{1'b0, ~result_o.data};
  end
endmodule

// ==== testbench/test_tvfc_top.sv ====
`timescale 1ns/1ps
`include "tvfc_consts.svh"

module test_tvfc_top
  import tvfc_pkg::*;
;
  logic clk_i = 0, rst_n_i = 0, board_reset_i = 0, start_i = 0, dut_ready_i = 0;
  logic crc_mode_i = 0, count_rd_i = 0, go = 0, flip = 0, stall = 0, flip_all = 0;
  logic rd_ff = 0, prev_v = 0, result_ready_o, error_flag_o, busy_o, tx_ready_i;
  logic [2:0] mode_sel_i = 0, mode_o;
  logic [13:0] crc_chains_i = 0;
  logic [7:0] count_o;
  logic [31:0] seed = 32'h9DC7;
  tvfc_load_t load_i = '0;
  tvfc_bus_t tx_o, result_i;
  logic [7:0] mem[$];
  logic [7:0] exp_q[$];
  int bad_count = 0, tests_run = 0, errs = 0, idx = 0, base, snap = 0;

  tvfc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .board_reset_i(board_reset_i),
    .load_i(load_i), .start_i(start_i), .dut_ready_i(dut_ready_i), .mode_sel_i(mode_sel_i),
    .crc_mode_i(crc_mode_i), .crc_chains_i(crc_chains_i), .count_rd_i(count_rd_i),
    .count_o(count_o), .result_ready_o(result_ready_o), .error_flag_o(error_flag_o),
    .busy_o(busy_o), .mode_o(mode_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .result_i(result_i));
  tvfc_partner u_partner (.clk_i(clk_i), .tx_i(tx_o), .mode_i(mode_o), .tx_ready_o(tx_ready_i),
    .result_o(result_i), .go_i(go), .flip_i(flip), .stall_i(stall), .chains_i(crc_chains_i));

  // ========
  // clock and random source
  always #5 clk_i = ~clk_i;
  // xorshift step of the random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  always @(posedge clk_i)
  begin
    seed <= xs(seed);
    stall <= seed[1] | seed[0];
    flip <= (seed[2] & seed[3]) | flip_all;
  end

  // reference comparison of returned bytes, count of expected mismatches
  always @(posedge clk_i)
  begin
    prev_v <= result_i.valid;
    rd_ff <= count_rd_i;
    base = crc_mode_i ? mem.size() - int'(crc_chains_i) : 0;
    if (result_i.valid && (!crc_mode_i || mode_o == `TVFC_MODE_CRC_PULL))
    begin
      idx = prev_v ? idx + 1 : 0;
      if (result_i.data !== mem[base + idx])
        errs <= errs + 1;
    end
  end

  // each count read answer against the oldest note
  always @(negedge clk_i)
    if (rd_ff)
      chk("count", exp_q.pop_front(), count_o);

  // ========
  // tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic rd();
    @(posedge clk_i);
    exp_q.push_back(8'(errs - snap));
    snap = errs;
    count_rd_i <= 1;
    @(posedge clk_i);
    count_rd_i <= 0;
  endtask

  task automatic run(input int n, input logic crc, input int ch, input logic all);
    int k;
    logic [7:0] b;
    @(posedge clk_i);
    board_reset_i <= 1;
    dut_ready_i <= 0;
    crc_mode_i <= crc;
    crc_chains_i <= ch[13:0];
    mode_sel_i <= {1'b0, seed[1:0]};
    flip_all <= all;
    mem.delete();
    @(posedge clk_i);
    board_reset_i <= 0;
    for (k = 0; k < n; k++)
    begin
      @(posedge clk_i);
      // crc runs store copies of the bytes that the partner returns per chain
      b = (crc && k >= n - ch) ? mem[k - ch] : seed[15:8];
      load_i <= '{1'b1, k == n - 1, b};
      mem.push_back(b);
    end
    @(posedge clk_i);
    load_i <= '0;
    start_i <= 1;
    rd();
    @(negedge clk_i);
    chk("busy", 8'h00, {7'h00, busy_o});
    @(posedge clk_i);
    start_i <= 1;
    dut_ready_i <= 1;
    @(posedge clk_i);
    start_i <= 0;
    for (k = 0; k < 20000 && result_ready_o !== 1'b1; k++)
      @(posedge clk_i);
    chk("ready", 8'h01, {7'h00, result_ready_o});
    go <= !crc;
    @(posedge clk_i);
    go <= 0;
    // a read in mid-burst of a non-crc run; with every byte flipped it meets a mismatch in the same clock
    repeat (n / 2) @(posedge clk_i);
    rd();
    repeat (n / 2 + 20) @(posedge clk_i);
    rd();
    rd();
    $display("test n=%0d crc=%0d done", n, crc);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ========
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1;
    run(20, 0, 0, 0);
    run(300, 0, 0, 1);
    run(12, 1, 3, 0);
    run(10, 1, 4, 1);
    summarize();
  end

  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
